// ==== verilog/motor_bridge_pwm_control.sv ====
/*
 * Control logic for one DC bridge and two stepper bridges: APB register
 * slave, output state decode, synchronous rectification, sleep and
 * protection. Analog comparators and detectors arrive as digital inputs
 * on clk_in; power stages act on the registered drive outputs.
 */
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module motor_bridge_pwm_control
    import motor_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // APB slave
    input  wire logic [7:0]  paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Analog detectors
    input  wire logic [2:0]  current_trip_in,
    input  wire logic [2:0]  zero_current_in,
    input  wire logic        short_detect_in,
    input  wire logic        junction_hot_in,
    input  wire logic        pump_gate_supply_low_in,
    input  wire logic        supply_above_threshold_in,
    // Bridge drive
    output logic      [2:0]  bridge_out_a_out,
    output logic      [2:0]  bridge_out_b_out,
    output logic      [2:0]  bridge_drive_en_out,
    output logic      [2:0]  sync_rectify_out,
    output logic      [2:0]  current_limit_chop_out,
    output logic      [3:0]  trip_pct_out,
    output logic             pump_enable_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  ctrl;
        logic [5:0]  step;
        logic [2:0]  trip_s1;  // First synchroniser stage only
        logic [2:0]  trip_s2;
        logic        short_fault;
        logic [2:0]  zero_seen;
        logic [2:0]  out_a;
        logic [2:0]  out_b;
        logic [2:0]  drv_en;
        logic [2:0]  sr;
        logic [2:0]  chop;
        logic [3:0]  pct;
        logic        pump_en;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ctl_s;

    ctl_s s;
    ctl_s next_s;

    chop_st_e   ph [N_BR];
    logic [2:0] run;
    logic [2:0] dir;
    logic       ok;
    logic       awake;
    logic       access;

    // ------------------------------------------------------------
    // Per-bridge chop sequencers
    // ------------------------------------------------------------
    for (genvar b = 0; b < N_BR; b++) begin : g_br
        bridge_chop #(
            .BLANK_CYC (b == 0 ? BLANK_DC_CYC : BLANK_ST_CYC),
            .MIXED     (b != 0)
        ) u_chop (
            .clk_in    (clk_in),
            .rst_n_in  (rst_n_in),
            .run_in    (run[b]),
            .trip_in   (s.trip_s2[b]),
            .slow_in   (s.ctrl[CTL_SLOW]),
            .phase_out (ph[b])
        );
    end

    // ------------------------------------------------------------
    // Enables shared by all bridges
    // ------------------------------------------------------------
    always_comb begin
        awake  = s.ctrl[CTL_WAKE];
        ok     = awake && !s.short_fault && !junction_hot_in &&
                 !pump_gate_supply_low_in && supply_above_threshold_in;
        access = psel_in && penable_in && s.pready;
        dir[0] = s.ctrl[CTL_DIR];
        run[0] = ok && s.ctrl[CTL_EN];
        for (int i = 1; i < N_BR; i++) begin
            dir[i] = s.step[(i - 1) * STP_W + STP_DIR];
            // both level bits high turns the bridge off
            run[i] = ok && !(s.step[(i - 1) * STP_W + STP_HI] &&
                             s.step[(i - 1) * STP_W + STP_LO]);
        end
    end

    // ------------------------------------------------------------
    // Next state: bus, protection and output decode
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;

        next_s.trip_s1 = current_trip_in;
        next_s.trip_s2 = s.trip_s1;

        // APB: answer in the access phase, zero wait states
        next_s.pready  = psel_in && !penable_in;
        next_s.pslverr = 1'b0;
        next_s.prdata  = 32'h0000_0000;
        if (psel_in && !penable_in) begin
            unique case (paddr_in)
                CTRL_OFS: next_s.prdata[3:0] = s.ctrl;
                STEP_OFS: next_s.prdata[5:0] = s.step;
                STAT_OFS: begin
                    next_s.prdata[STS_SHORT] = s.short_fault;
                    next_s.prdata[STS_HOT]   = junction_hot_in;
                    next_s.prdata[STS_PUMP]  = pump_gate_supply_low_in;
                    next_s.prdata[STS_LOCK]  = !supply_above_threshold_in;
                    next_s.prdata[STS_SLEEP] = !awake;
                    next_s.prdata[STS_CHOP +: 3] = s.chop;
                end
                default: next_s.pslverr = 1'b1;
            endcase
        end
        if (access && pwrite_in) begin
            if (paddr_in == CTRL_OFS) begin
                next_s.ctrl = pwdata_in[3:0];
            end
            if (paddr_in == STEP_OFS) begin
                next_s.step = pwdata_in[5:0];
            end
        end

        // short latch; set wins over the sleep clear
        if (short_detect_in) begin
            next_s.short_fault = 1'b1;
        end else if (!awake) begin
            next_s.short_fault = 1'b0;
        end

        // charge pump follows the sleep request
        next_s.pump_en = awake;

        // trip share code per stepper bridge
        next_s.pct = ~{s.step[4], s.step[3], s.step[1], s.step[0]};

        for (int b = 0; b < N_BR; b++) begin
            // zero-current memory, held through one decay
            if ((run[b] && (ph[b] == ST_FAST || ph[b] == ST_SLOW)) ||
                (b == 0 && ok && !s.ctrl[CTL_EN])) begin
                next_s.zero_seen[b] = s.zero_seen[b] || zero_current_in[b];
            end else begin
                next_s.zero_seen[b] = 1'b0;
            end
            next_s.chop[b]   = run[b] && ph[b] != ST_ON;
            next_s.out_a[b]  = 1'b0;
            next_s.out_b[b]  = 1'b0;
            next_s.drv_en[b] = 1'b0;
            next_s.sr[b]     = 1'b0;
            if (!ok) begin
                // Outputs float; nothing else to do
            end else if (b == 0 && !s.ctrl[CTL_EN]) begin
                next_s.sr[0] = 1'b1;
                if (s.ctrl[CTL_SLOW]) begin
                    next_s.drv_en[0] = 1'b1;
                end else begin
                    next_s.out_a[0]  = !dir[0];
                    next_s.out_b[0]  = dir[0];
                    next_s.drv_en[0] = !s.zero_seen[0];
                end
            end else if (run[b]) begin
                unique case (ph[b])
                    ST_ON: begin
                        next_s.out_a[b]  = dir[b];
                        next_s.out_b[b]  = !dir[b];
                        next_s.drv_en[b] = 1'b1;
                    end
                    ST_FAST: begin
                        next_s.out_a[b]  = !dir[b];
                        next_s.out_b[b]  = dir[b];
                        next_s.drv_en[b] = !s.zero_seen[b];
                        next_s.sr[b]     = !s.zero_seen[b];
                    end
                    ST_DEAD: begin
                        next_s.drv_en[b] = 1'b0;
                    end
                    ST_SLOW: begin
                        next_s.drv_en[b] = !s.zero_seen[b];
                        next_s.sr[b]     = !s.zero_seen[b];
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Control resets asleep so nothing drives before software asks
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s      <= '0;
            s.ctrl <= CTRL_RST;
            s.step <= STEP_RST;
            s.pct  <= {PCT_OFF, PCT_OFF};
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign prdata_out             = s.prdata;
    assign pready_out             = s.pready;
    assign pslverr_out            = s.pslverr;
    assign bridge_out_a_out       = s.out_a;
    assign bridge_out_b_out       = s.out_b;
    assign bridge_drive_en_out    = s.drv_en;
    assign sync_rectify_out       = s.sr;
    assign current_limit_chop_out = s.chop;
    assign trip_pct_out           = s.pct;
    assign pump_enable_out        = s.pump_en;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    fwd_drive_a: assert property (
        (run[0] && dir[0] && ph[0] == ST_ON)
        |=> (bridge_out_a_out[0] && !bridge_out_b_out[0] &&
             bridge_drive_en_out[0]))
        else $error("forward drive wrong");

    rev_drive_a: assert property (
        (run[0] && !dir[0] && ph[0] == ST_ON)
        |=> (!bridge_out_a_out[0] && bridge_out_b_out[0] &&
             bridge_drive_en_out[0]))
        else $error("reverse drive wrong");

    dc_brake_a: assert property (
        (ok && !s.ctrl[CTL_EN] && s.ctrl[CTL_SLOW])
        |=> (bridge_drive_en_out[0] && !bridge_out_a_out[0] &&
             !bridge_out_b_out[0] && sync_rectify_out[0]))
        else $error("brake output wrong");

    fast_chop_a: assert property (
        (run[0] && ph[0] == ST_FAST && !s.zero_seen[0])
        |=> (bridge_out_a_out[0] == !$past(dir[0]) &&
             bridge_out_b_out[0] == $past(dir[0]) &&
             current_limit_chop_out[0]))
        else $error("fast chop drive wrong");

    dead_off_a: assert property (
        (ok && ph[1] == ST_DEAD)
        |=> (!bridge_drive_en_out[1] && !sync_rectify_out[1]))
        else $error("driver on in dead time");

    // Sleep one cycle after the short may clear the latch legally
    short_latch_a: assert property (
        short_detect_in |=> s.short_fault ##1
        ((s.short_fault || !$past(awake)) &&
         bridge_drive_en_out == 3'h0))
        else $error("short fault not latched");

    hot_off_a: assert property (
        (junction_hot_in || pump_gate_supply_low_in)
        |=> bridge_drive_en_out == 3'h0)
        else $error("outputs on during fault");

    step_off_a: assert property (
        (s.step[STP_HI] && s.step[STP_LO])
        |=> (trip_pct_out[1:0] == PCT_OFF && !bridge_drive_en_out[1]))
        else $error("stepper not off at level 11");

    dc_rectify_a: assert property (
        (ok && !s.ctrl[CTL_EN]) |=> sync_rectify_out[0])
        else $error("rectify off with enable low");

endmodule

`default_nettype wire

// ==== verilog/motor_pkg.sv ====
/*
 * Shared constants for the three-bridge motor control logic: register map,
 * field positions, reset values, chop timing counts and phase codes.
 * Assumes a 40 MHz system clock; all timing counts derive from it.
 */
`default_nettype none

package motor_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 40;
    localparam int OFF_NS       = 30_000;  // Fixed off-time
    localparam int FAST_PERMIL  = 301;     // Fast share of off-time
    localparam int DEAD_NS      = 600;     // Fast-to-slow dead time
    localparam int BLANK_ST_NS  = 1_000;   // Stepper blanking
    localparam int BLANK_DC_NS  = 3_000;   // DC blanking
    localparam int OFF_CYC      = OFF_NS * CLK_MHZ / 1000;
    localparam int FAST_CYC     = OFF_NS * FAST_PERMIL / 1000
                                  * CLK_MHZ / 1000;
    localparam int DEAD_CYC     = DEAD_NS * CLK_MHZ / 1000;
    localparam int SLOW_CYC     = OFF_CYC - FAST_CYC - DEAD_CYC;
    localparam int BLANK_ST_CYC = BLANK_ST_NS * CLK_MHZ / 1000;
    localparam int BLANK_DC_CYC = BLANK_DC_NS * CLK_MHZ / 1000;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STEP_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;

    // Control register fields and reset (asleep, disabled)
    localparam int         CTL_DIR  = 0;
    localparam int         CTL_EN   = 1;
    localparam int         CTL_SLOW = 2;
    localparam int         CTL_WAKE = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // Stepper register: three bits per bridge, levels reset to off
    localparam int         STP_LO   = 0;
    localparam int         STP_HI   = 1;
    localparam int         STP_DIR  = 2;
    localparam int         STP_W    = 3;
    localparam logic [5:0] STEP_RST = 6'h1B;

    // Status register fields
    localparam int STS_SHORT = 0;
    localparam int STS_HOT   = 1;
    localparam int STS_PUMP  = 2;
    localparam int STS_LOCK  = 3;
    localparam int STS_SLEEP = 4;
    localparam int STS_CHOP  = 5;  // One bit per bridge from here

    // ------------------------------------------------------------
    // Bridges, trip levels and chop phases
    // ------------------------------------------------------------
    localparam int N_BR = 3;  // Bridge 0 is the DC bridge

    localparam logic [1:0] PCT_OFF = 2'h0;

    typedef enum logic [3:0] {
        ST_ON   = 4'b0001,
        ST_FAST = 4'b0010,
        ST_DEAD = 4'b0100,
        ST_SLOW = 4'b1000
    } chop_st_e;

endpackage

`default_nettype wire

// ==== verilog/bridge_chop.sv ====
/*
 * Fixed off-time chop sequencer for one bridge: on-phase with blanking,
 * then fast, dead and slow decay (mixed) or one decay kind (plain).
 * Assumes trip_in is already synchronised to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module bridge_chop
    import motor_pkg::*;
#(
    parameter int BLANK_CYC = BLANK_ST_CYC,
    parameter bit MIXED     = 1'b1
) (
    // Clock and reset
    input  wire logic     clk_in,
    input  wire logic     rst_n_in,
    // Control
    input  wire logic     run_in,
    input  wire logic     trip_in,
    input  wire logic     slow_in,
    // Phase
    output var  chop_st_e phase_out
);

    // ------------------------------------------------------------
    // Checks and state
    // ------------------------------------------------------------
    if (BLANK_CYC < 1 || BLANK_CYC > 127) begin : g_bad_blank
        $error("bridge_chop: blank count out of range");
    end

    typedef struct packed {
        chop_st_e    st;
        logic [10:0] cnt;
        logic [6:0]  blank;
        logic [10:0] off_len;  // Cycles spent off, for checking
    } chop_s;

    chop_s s;
    chop_s next_s;

    // Sequencer
    always_comb begin
        next_s = s;
        if (s.blank != 7'h00) begin
            next_s.blank = s.blank - 7'h01;
        end
        next_s.off_len = (s.st == ST_ON) ? 11'h000 : s.off_len + 11'h001;
        if (!run_in) begin
            // Re-enable switches outputs, so blanking restarts
            next_s.st    = ST_ON;
            next_s.cnt   = 11'h000;
            next_s.blank = 7'(BLANK_CYC);
        end else begin
            unique case (s.st)
                ST_ON: begin
                    if (s.blank == 7'h00 && trip_in) begin
                        next_s.blank = 7'(BLANK_CYC);
                        next_s.cnt = MIXED ? 11'(FAST_CYC - 1)
                                           : 11'(OFF_CYC - 1);
                        next_s.st = (MIXED || !slow_in) ? ST_FAST
                                                         : ST_SLOW;
                    end
                end
                ST_FAST: begin
                    if (s.cnt != 11'h000) begin
                        next_s.cnt = s.cnt - 11'h001;
                    end else if (MIXED) begin
                        next_s.st  = ST_DEAD;
                        next_s.cnt = 11'(DEAD_CYC - 1);
                    end else begin
                        next_s.st    = ST_ON;
                        next_s.blank = 7'(BLANK_CYC);
                    end
                end
                ST_DEAD: begin
                    if (s.cnt != 11'h000) begin
                        next_s.cnt = s.cnt - 11'h001;
                    end else begin
                        next_s.st    = ST_SLOW;
                        next_s.cnt   = 11'(SLOW_CYC - 1);
                        next_s.blank = 7'(BLANK_CYC);
                    end
                end
                ST_SLOW: begin
                    if (s.cnt != 11'h000) begin
                        next_s.cnt = s.cnt - 11'h001;
                    end else begin
                        next_s.st    = ST_ON;
                        next_s.blank = 7'(BLANK_CYC);
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '{st: ST_ON, cnt: 11'h000, blank: 7'h00,
                   off_len: 11'h000};
        end else begin
            s <= next_s;
        end
    end

    assign phase_out = s.st;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    off_time_a: assert property (
        (s.st != ST_ON && next_s.st == ST_ON && run_in)
        |-> s.off_len == 11'(OFF_CYC - 1))
        else $error("off-time length wrong");

    blank_hold_a: assert property (
        (s.st == ST_ON && s.blank != 7'h00 && run_in) |=> s.st == ST_ON)
        else $error("trip taken inside blanking");

    fast_len_a: assert property (
        (MIXED && run_in && s.st == ST_ON && next_s.st == ST_FAST)
        |=> (s.cnt == 11'(FAST_CYC - 1) && s.st == ST_FAST))
        else $error("fast portion not loaded");

    dead_gap_a: assert property (
        (run_in && s.st == ST_FAST && next_s.st == ST_DEAD)
        ##1 (run_in && s.st == ST_DEAD) [*8]
        |=> s.st == ST_DEAD)
        else $error("dead time ended early");

endmodule

`default_nettype wire

// ==== test/load_model.sv ====
/* Winding stand-in: raises a bridge's comparator once it has been
   driven for RAMP on-phase cycles. Assumes the block's chop flags. */
`timescale 1ns/1ps
`default_nettype none
module load_model #(parameter int RAMP = 200) (
    // Clock, reset, bench arm and block outputs
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [2:0] arm_in,
    input  wire logic [2:0] drive_in,
    input  wire logic [2:0] chop_in,
    // Comparator levels
    output logic      [2:0] trip_out
);
    int cnt [3];
    // Current falls back during a chop, so the trip drops there
    always @(posedge clk_in or negedge rst_n_in) begin
        for (int i = 0; i < 3; i++) begin
            if (!rst_n_in || !arm_in[i] || chop_in[i])
                cnt[i] <= 0;
            else if (drive_in[i])
                cnt[i] <= cnt[i] + 1;
            trip_out[i] <= rst_n_in && arm_in[i] && !chop_in[i]
                           && cnt[i] >= RAMP;
        end
    end
endmodule
`default_nettype wire

// ==== test/motor_bridge_pwm_control_tb.sv ====
/* Bench for the bridge control block: APB tasks, drive decode, chop
   timing, protection. Assumes the load model for the comparators. */
`timescale 1ns/1ps
`default_nettype none
module motor_bridge_pwm_control_tb
    import motor_pkg::*;
;
    logic clk_in = 0, rst_n_in = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, d;
    logic pready, pslverr, pump, hot = 0, plow = 0, sup = 1, shrt = 0;
    logic [2:0] trip, a, b, den, sr, chop, zero = 0, arm = 0;
    logic [3:0] pct, snap;
    logic zsnap;
    logic [32:0] q [$];
    int bad_count = 0, check_count = 0, cyc = 0, len, fc, dz, srd, seed;
    // Pump and regulator settle time after wake, about 200 us
    localparam int WAKE_CYC = 8000;

    always #12.5 clk_in = ~clk_in;
    motor_bridge_pwm_control i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .current_trip_in(trip), .zero_current_in(zero),
        .short_detect_in(shrt), .junction_hot_in(hot),
        .pump_gate_supply_low_in(plow), .supply_above_threshold_in(sup),
        .bridge_out_a_out(a), .bridge_out_b_out(b),
        .bridge_drive_en_out(den), .sync_rectify_out(sr),
        .current_limit_chop_out(chop), .trip_pct_out(pct),
        .pump_enable_out(pump));
    load_model i_load (.clk_in(clk_in), .rst_n_in(rst_n_in), .arm_in(arm),
        .drive_in(den), .chop_in(chop), .trip_out(trip));

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Request held until pready is seen; the note goes to the queue
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd, input logic [32:0] exp);
        q.push_back(exp);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Oldest note against each finished access; writes show only errors
    always @(posedge clk_in) begin
        cyc++;
        if (psel && penable && pready === 1'b1) begin
            if (pwrite)
                check(pslverr, q[0][32]);
            else
                check({pslverr, prdata}, q[0]);
            void'(q.pop_front());
        end
        // Two wake waits plus chop runs fit well inside this ceiling
        if (cyc == 40000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // One off-time: length, fast share, dead gap, and a zero-current hit
    task automatic chop_run(input int br);
        len = 0;
        fc = 0;
        dz = 0;
        srd = 0;
        repeat (3000) begin
            @(posedge clk_in);
            if (chop[br] === 1'b1)
                break;
        end
        arm <= 3'b000;
        while (chop[br] === 1'b1) begin
            len++;
            if (len == 4)
                snap = {a[br], b[br], den[br], sr[br]};
            if (len == 14)
                zsnap = den[br];
            zero[0] <= (br == 0 && len >= 8 && len < 14);
            if (den[br] === 1'b0)
                dz++;
            else if (dz == 0)
                fc++;
            if (den[br] === 1'b0 && sr[br] === 1'b1)
                srd++;
            @(posedge clk_in);
        end
    endtask

    initial begin
        seed = $urandom(32'hF682044D);
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0, 33'h0);
        apb(1'b0, STEP_OFS, 32'h0, {27'h0, STEP_RST});
        apb(1'b0, STAT_OFS, 32'h0, 33'h10);
        apb(1'b1, 8'h0C, 32'hFFFFFFFF, {1'b1, 32'h0});
        apb(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0});
        check(pump, 1'b0);
        // Every direction, enable and decay select with no trip
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, CTRL_OFS, {29'h1, i[2:0]}, 33'h0);
            // first wake: settle before expecting drive
            repeat (i == 0 ? WAKE_CYC : 3) @(posedge clk_in);
            snap = {a[0], b[0], den[0], sr[0]};
            if (i[1])
                check({a[0], b[0]}, {i[0], ~i[0]});
            else if (i[2])
                check({a[0], b[0], sr[0]}, 3'b001);
            else
                check(snap, {~i[0], i[0], 2'h3});
        end
        check(pump, 1'b1);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, CTRL_OFS, {29'h1, s[0], 2'h3}, 33'h0);
            arm <= 3'b001;
            chop_run(0);
            check(len, OFF_CYC);
            check(snap, s[0] ? 4'h3 : 4'h7);
            check(zsnap, 1'b0);
        end
        d = $urandom;
        apb(1'b1, STEP_OFS, {d[31:6], d[5], 2'h3, d[2], 2'h0}, 33'h0);
        arm <= 3'b010;
        chop_run(1);
        check(len, OFF_CYC);
        check(fc, FAST_CYC);
        check(dz, DEAD_CYC);
        check(srd, 0);
        for (int k = 0; k < 4; k++) begin
            d = $urandom;
            d[5:0] = {d[5], k[1:0], d[2], k[1:0]};
            apb(1'b1, STEP_OFS, d, 33'h0);
            apb(1'b0, STEP_OFS, 32'h0, {27'h0, d[5:0]});
            check(pct, {2{~k[1], ~k[0]}});
        end
        // Short latches through its removal; sleep clears it
        shrt <= 1'b1;
        @(posedge clk_in);
        shrt <= 1'b0;
        repeat (8) @(posedge clk_in);
        check(den, 3'b000);
        apb(1'b0, STAT_OFS, 32'h0, 33'h01);
        apb(1'b1, CTRL_OFS, 32'h3, 33'h0);
        apb(1'b1, CTRL_OFS, 32'hB, 33'h0);
        // woken again: settle before expecting drive
        repeat (WAKE_CYC) @(posedge clk_in);
        check(den[0], 1'b1);
        for (int j = 0; j < 3; j++) begin
            {hot, plow, sup} <= {j == 0, j == 1, j != 2};
            repeat (4) @(posedge clk_in);
            check(den[0], 1'b0);
            {hot, plow, sup} <= 3'b001;
            repeat (4) @(posedge clk_in);
            check(den[0], 1'b1);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
